/* bet_trigger_eval.sv */
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module bet_trigger_eval
    import bet_pkg::*;
#(
    parameter int NUM_BEAMS = 32
)(
    input  wire logic                       i_sys_clk,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_hsel,
    input  wire logic [31:0]                i_haddr,
    input  wire logic [1:0]                 i_htrans,
    input  wire logic                       i_hwrite,
    input  wire logic [2:0]                 i_hsize,
    input  wire logic [31:0]                i_hwdata,
    input  wire logic                       i_hready,
    output logic                            o_hreadyout,
    output logic                            o_hresp,
    output logic [31:0]                     o_hrdata,
    input  wire logic                       i_ready,
    input  wire logic                       i_scan_valid,
    input  wire logic [NUM_BEAMS-1:0]       i_beam_free,
    input  wire logic [bet_pkg::TEACH_W-1:0] i_teach_level,
    input  wire logic [bet_pkg::TEACH_W-1:0] i_nv_teach,
    input  wire logic                       i_trig_in,
    output logic                            o_trig_out,
    output logic                            o_meas_start,
    output logic                            o_teach_store,
    output logic [bet_pkg::TEACH_W-1:0]     o_teach_value,
    output logic                            o_eval_valid,
    output logic [NUM_BEAMS-1:0]            o_beams_eval,
    output logic [bet_pkg::HALF_W-1:0]      o_area_bits_upper_word,
    output logic [bet_pkg::HALF_W-1:0]      o_area_bits_lower_word
);
    import bet_pkg::*;

    logic rst_meta, rst_n;
    logic trig_meta, trig_sync, trig_prev;

    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // the trigger pin is asynchronous to us
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
            trig_prev <= 1'b0;
        end
        else
        begin
            trig_meta <= i_trig_in;
            trig_sync <= trig_meta;
            trig_prev <= trig_sync;
        end
    end

    // register file and bus slave
    bet_ctrl_s             ctrl, next_ctrl;
    logic [SMOOTH_W-1:0]   smooth_min, next_smooth_min;
    logic [15:0]           trig_delay, next_trig_delay;
    logic [15:0]           trig_period, next_trig_period;
    logic [15:0]           hold_us, next_hold_us;
    logic [5:0]            split_cnt, next_split_cnt;
    logic [31:0]           blank, next_blank;
    bet_area_s             area_cfg [AREA_NUM];
    bet_area_s             next_area_cfg [AREA_NUM];
    logic                  wr_pend, next_wr_pend;
    logic [11:0]           wr_addr, next_wr_addr;
    logic [31:0]           next_hrdata, rd_value;
    logic                  addr_ok;

    bet_teach_e            teach_state;
    logic                  teach_ok, teach_fail, pend;
    logic [TEACH_W-1:0]    stored;
    logic [AREA_NUM-1:0]   held;

    assign addr_ok     = i_hsel && i_htrans[1] && i_hready;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    always_comb
    begin
        rd_value = 32'h0000_0000;
        case (i_haddr[11:0])
            OFF_CTRL:        rd_value = {27'h0, ctrl};
            OFF_SMOOTH:      rd_value = {24'h0, smooth_min};
            OFF_TRIG_DELAY:  rd_value = {16'h0, trig_delay};
            OFF_TRIG_PERIOD: rd_value = {16'h0, trig_period};
            OFF_HOLD:        rd_value = {16'h0, hold_us};
            OFF_SPLIT_CNT:   rd_value = {26'h0, split_cnt};
            OFF_BLANK:       rd_value = blank;
            OFF_STATUS:      rd_value = {28'h0, pend, teach_fail, teach_ok, teach_state == TS_DONE};
            OFF_TEACH_VAL:   rd_value = {16'h0, stored};
            OFF_AREA_OUT:    rd_value = held;
            OFF_BEAMS:       rd_value = 32'(o_beams_eval);
            default:
                if (i_haddr[11:7] == OFF_AREA_BASE[11:7])
                    rd_value = {15'h0, area_cfg[i_haddr[6:2]]};
        endcase
        next_wr_pend     = addr_ok && i_hwrite && (i_hsize == SIZE_WORD);
        next_wr_addr     = addr_ok ? i_haddr[11:0] : wr_addr;
        next_hrdata      = (addr_ok && !i_hwrite) ? rd_value : o_hrdata;
        next_ctrl        = ctrl;
        next_smooth_min  = smooth_min;
        next_trig_delay  = trig_delay;
        next_trig_period = trig_period;
        next_hold_us     = hold_us;
        next_split_cnt   = split_cnt;
        next_blank       = blank;
        next_area_cfg    = area_cfg;
        if (wr_pend)
        begin
            case (wr_addr)
                OFF_CTRL:        next_ctrl        = bet_ctrl_s'(i_hwdata[4:0]);
                OFF_SMOOTH:      next_smooth_min  = i_hwdata[7:0];
                OFF_TRIG_DELAY:  next_trig_delay  = i_hwdata[15:0];
                OFF_TRIG_PERIOD: next_trig_period = i_hwdata[15:0];
                OFF_HOLD:        next_hold_us     = i_hwdata[15:0];
                OFF_SPLIT_CNT:   next_split_cnt   = i_hwdata[5:0];
                OFF_BLANK:       next_blank       = i_hwdata;
                default:
                    if (wr_addr[11:7] == OFF_AREA_BASE[11:7])
                        next_area_cfg[wr_addr[6:2]] = bet_area_s'(i_hwdata[16:0]);
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl        <= bet_ctrl_s'(CTRL_RST);
            smooth_min  <= SMOOTH_RST;
            trig_delay  <= 16'h0000;
            trig_period <= TRIG_PERIOD_RST;
            hold_us     <= 16'h0000;
            split_cnt   <= SPLIT_CNT_RST;
            blank       <= 32'h0000_0000;
            area_cfg    <= '{default: '0};
            wr_pend     <= 1'b0;
            wr_addr     <= 12'h000;
            o_hrdata    <= 32'h0000_0000;
        end
        else
        begin
            ctrl        <= next_ctrl;
            smooth_min  <= next_smooth_min;
            trig_delay  <= next_trig_delay;
            trig_period <= next_trig_period;
            hold_us     <= next_hold_us;
            split_cnt   <= next_split_cnt;
            blank       <= next_blank;
            area_cfg    <= next_area_cfg;
            wr_pend     <= next_wr_pend;
            wr_addr     <= next_wr_addr;
            o_hrdata    <= next_hrdata;
        end
    end

    reg_write_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (wr_pend && wr_addr == OFF_SMOOTH) |=> (smooth_min == $past(i_hwdata[7:0])))
        else $error("smoothing register missed a bus write");

    // teach sequence after power-up
    bet_teach_e            next_teach_state;
    logic                  next_teach_ok, next_teach_fail, next_teach_store;
    logic [TEACH_W-1:0]    next_stored;
    logic                  scan_clear;

    // blanked beams are excluded from the judgement
    assign scan_clear = &(i_beam_free | blank[NUM_BEAMS-1:0]);

    always_comb
    begin
        next_teach_state = teach_state;
        next_teach_ok    = teach_ok;
        next_teach_fail  = teach_fail;
        next_teach_store = 1'b0;
        next_stored      = stored;
        case (teach_state)
            TS_IDLE:
                if (i_ready)
                begin
                    next_stored      = i_nv_teach;
                    next_teach_state = ctrl.pu_teach_en ? TS_START : TS_DONE;
                end
            TS_START:
                next_teach_state = TS_WAIT;
            TS_WAIT:
                if (i_scan_valid)
                begin
                    next_teach_state = TS_DONE;
                    next_teach_ok    = scan_clear;
                    next_teach_fail  = !scan_clear;
                    if (scan_clear && i_teach_level != stored)
                    begin
                        next_stored      = i_teach_level;
                        next_teach_store = 1'b1;
                    end
                end
            TS_DONE:
                next_teach_state = TS_DONE;
            default:
                next_teach_state = TS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            teach_state   <= TS_IDLE;
            teach_ok      <= 1'b0;
            teach_fail    <= 1'b0;
            o_teach_store <= 1'b0;
            stored        <= '0;
        end
        else
        begin
            teach_state   <= next_teach_state;
            teach_ok      <= next_teach_ok;
            teach_fail    <= next_teach_fail;
            o_teach_store <= next_teach_store;
            stored        <= next_stored;
        end
    end

    assign o_teach_value = stored;

    teach_fail_keep_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (teach_state == TS_WAIT && i_scan_valid && !scan_clear) |=> (stored == $past(stored) && !o_teach_store))
        else $error("failed teach changed stored values");
    teach_store_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (teach_state == TS_WAIT && i_scan_valid && scan_clear && i_teach_level != stored)
        |=> (o_teach_store && stored == $past(i_teach_level)) ##1 !o_teach_store)
        else $error("successful teach did not store new values");
    teach_off_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (teach_state == TS_IDLE && i_ready && !ctrl.pu_teach_en) |=> (teach_state == TS_DONE) ##1 !o_meas_start)
        else $error("teach ran while disabled");

    // trigger generation, delay and measurement start
    logic [7:0]  us_cnt, next_us_cnt;
    logic [15:0] int_cnt, next_int_cnt;
    logic [7:0]  pulse_cnt, next_pulse_cnt;
    logic [15:0] dly_cnt, next_dly_cnt;
    logic        next_pend, next_meas_start, us_tick, fire, trig_edge, accept;

    assign us_tick   = (us_cnt == 8'(US_CYC - 1));
    // a master starts its own scan from its own pulse, not a looped-back pin
    // a period of 0 would wrap the compare, so it runs like a period of 1
    assign fire      = ctrl.trig_internal && us_tick
                     && (trig_period <= 16'h0001 || int_cnt >= 16'(trig_period - 16'h0001));
    assign trig_edge = ctrl.trig_internal ? fire : (trig_sync && !trig_prev);
    // edges during teach or a pending delay are dropped, not queued
    assign accept    = trig_edge && (teach_state == TS_DONE) && !pend;

    always_comb
    begin
        next_us_cnt     = us_tick ? 8'h00 : 8'(us_cnt + 8'h01);
        next_int_cnt    = !ctrl.trig_internal ? 16'h0000 : fire ? 16'h0000
                        : us_tick ? 16'(int_cnt + 16'h0001) : int_cnt;
        next_pulse_cnt  = fire ? 8'(TRIG_PULSE_CYC) : (pulse_cnt != 8'h00 ? 8'(pulse_cnt - 8'h01) : 8'h00);
        next_pend       = pend;
        next_dly_cnt    = dly_cnt;
        next_meas_start = (teach_state == TS_START);
        if (accept)
        begin
            next_pend    = 1'b1;
            next_dly_cnt = trig_delay;
        end
        else if (pend)
        begin
            if (dly_cnt == 16'h0000)
            begin
                next_pend       = 1'b0;
                next_meas_start = 1'b1;
            end
            else if (us_tick)
                next_dly_cnt = 16'(dly_cnt - 16'h0001);
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            us_cnt       <= 8'h00;
            int_cnt      <= 16'h0000;
            pulse_cnt    <= 8'h00;
            o_trig_out   <= 1'b0;
            pend         <= 1'b0;
            dly_cnt      <= 16'h0000;
            o_meas_start <= 1'b0;
        end
        else
        begin
            us_cnt       <= next_us_cnt;
            int_cnt      <= next_int_cnt;
            pulse_cnt    <= next_pulse_cnt;
            o_trig_out   <= (next_pulse_cnt != 8'h00);
            pend         <= next_pend;
            dly_cnt      <= next_dly_cnt;
            o_meas_start <= next_meas_start;
        end
    end

    trig_delay0_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (accept && trig_delay == 16'h0000) |-> ##2 o_meas_start)
        else $error("zero-delay trigger did not start a measurement");
    trig_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        $rose(o_trig_out) |-> ##99 o_trig_out ##1 !o_trig_out)
        else $error("trigger output pulse width wrong");
    slave_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (!ctrl.trig_internal && !o_trig_out) |=> !o_trig_out)
        else $error("trigger output driven in external mode");

    // smoothing, then area reduction with hold
    logic                 sm_valid;
    logic [NUM_BEAMS-1:0] sm_free;

    bet_beam_smooth #(
        .NUM_BEAMS (NUM_BEAMS)
    ) u_smooth (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (rst_n),
        .i_valid   (i_scan_valid && teach_state == TS_DONE),
        .i_free    (i_beam_free | blank[NUM_BEAMS-1:0]),
        .i_min     (smooth_min),
        .i_invert  (ctrl.smooth_inv),
        .o_valid   (sm_valid),
        .o_free    (sm_free)
    );

    assign o_eval_valid = sm_valid;
    assign o_beams_eval = sm_free;

    function automatic logic area_eval(input logic [NUM_BEAMS-1:0] intr, input logic [7:0] s,
                                       input logic [7:0] e, input logic is_and);
        logic any_i, all_i, hit;
        any_i = 1'b0;
        all_i = 1'b1;
        hit   = 1'b0;
        for (int b = 0; b < NUM_BEAMS; b++)
            if (b + 1 >= int'(s) && b + 1 <= int'(e))
            begin
                hit   = 1'b1;
                any_i = any_i | intr[b];
                all_i = all_i & intr[b];
            end
        return is_and ? (hit & all_i) : any_i;
    endfunction : area_eval

    logic [AREA_NUM-1:0] cur_area, next_held;
    logic [15:0]         hold_cnt, next_hold_cnt;
    logic [5:0]          eff_cnt;
    logic [7:0]          span, s_b, e_b;

    always_comb
    begin
        eff_cnt = (split_cnt == 6'h00) ? 6'h01 : (split_cnt > 6'(NUM_BEAMS) ? 6'(NUM_BEAMS) : split_cnt);
        span    = 8'(NUM_BEAMS / int'(eff_cnt));
        s_b     = 8'h00;
        e_b     = 8'h00;
        for (int i = 0; i < AREA_NUM; i++)
        begin
            if (ctrl.split_en)
            begin
                s_b = 8'(i * int'(span) + 1);
                e_b = (i == int'(eff_cnt) - 1) ? 8'(NUM_BEAMS) : 8'((i + 1) * int'(span));
                cur_area[i] = (i < int'(eff_cnt)) && area_eval(~sm_free, s_b, e_b, ctrl.split_and);
            end
            else
                cur_area[i] = area_eval(~sm_free, area_cfg[i].start_beam, area_cfg[i].end_beam,
                                        area_cfg[i].is_and);
        end
        next_hold_cnt = (hold_cnt != 16'h0000 && us_tick) ? 16'(hold_cnt - 16'h0001) : hold_cnt;
        next_held     = held;
        // a set bit is kept until the hold period runs out
        if (sm_valid)
        begin
            if (hold_cnt == 16'h0000)
            begin
                next_held     = cur_area;
                next_hold_cnt = hold_us;
            end
            else
                next_held = held | cur_area;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            held     <= '0;
            hold_cnt <= 16'h0000;
        end
        else
        begin
            held     <= next_held;
            hold_cnt <= next_hold_cnt;
        end
    end

    assign o_area_bits_upper_word = held[AREA_NUM-1:HALF_W];
    assign o_area_bits_lower_word = held[HALF_W-1:0];

    area_pass_a: assert property (@(posedge i_sys_clk) disable iff (!rst_n)
        (sm_valid && hold_cnt == 16'h0000) |=> (held == $past(cur_area)))
        else $error("area bits not refreshed after hold expiry");
endmodule : bet_trigger_eval

/* bet_pkg.sv */
package bet_pkg;
    // register map, byte addresses on a 12-bit window
    localparam logic [11:0] OFF_CTRL        = 12'h000;
    localparam logic [11:0] OFF_SMOOTH      = 12'h004;
    localparam logic [11:0] OFF_TRIG_DELAY  = 12'h008;
    localparam logic [11:0] OFF_TRIG_PERIOD = 12'h00C;
    localparam logic [11:0] OFF_HOLD        = 12'h010;
    localparam logic [11:0] OFF_SPLIT_CNT   = 12'h014;
    localparam logic [11:0] OFF_BLANK       = 12'h018;
    localparam logic [11:0] OFF_STATUS      = 12'h01C;
    localparam logic [11:0] OFF_TEACH_VAL   = 12'h020;
    localparam logic [11:0] OFF_AREA_OUT    = 12'h024;
    localparam logic [11:0] OFF_BEAMS       = 12'h028;
    localparam logic [11:0] OFF_AREA_BASE   = 12'h100;

    localparam int          AREA_NUM     = 32;
    localparam int          HALF_W       = 16;
    localparam int          SMOOTH_W     = 8;
    localparam int          TEACH_W      = 16;
    localparam logic [2:0]  SIZE_WORD    = 3'h2;

    localparam logic [4:0]  CTRL_RST        = 5'h01;
    localparam logic [7:0]  SMOOTH_RST      = 8'h01;
    localparam logic [15:0] TRIG_PERIOD_RST = 16'h03E8;
    localparam logic [5:0]  SPLIT_CNT_RST   = 6'h20;

    localparam int CLK_PERIOD_NS  = 5;
    localparam int US_NS          = 1000;
    localparam int TRIG_PULSE_NS  = 500;
    localparam int US_CYC         = US_NS / CLK_PERIOD_NS;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        TS_IDLE  = 2'b00,
        TS_START = 2'b01,
        TS_WAIT  = 2'b10,
        TS_DONE  = 2'b11
    } bet_teach_e;

    typedef struct packed {
        logic split_and;
        logic split_en;
        logic smooth_inv;
        logic trig_internal;
        logic pu_teach_en;
    } bet_ctrl_s;

    typedef struct packed {
        logic       is_and;
        logic [7:0] end_beam;
        logic [7:0] start_beam;
    } bet_area_s;
endpackage : bet_pkg

/* bet_beam_smooth.sv */
`timescale 1ns/1ps
module bet_beam_smooth
    import bet_pkg::*;
#(
    parameter int NUM_BEAMS = 32
)(
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_valid,
    input  wire logic [NUM_BEAMS-1:0] i_free,
    input  wire logic [bet_pkg::SMOOTH_W-1:0] i_min,
    input  wire logic                 i_invert,
    output logic                      o_valid,
    output logic [NUM_BEAMS-1:0]      o_free
);
    import bet_pkg::*;

    logic [NUM_BEAMS-1:0] tgt;
    logic [NUM_BEAMS-1:0] next_free;
    logic [8:0]           lrun [NUM_BEAMS];
    logic [8:0]           rrun [NUM_BEAMS];

    // a beam survives when its run, counted both ways, reaches the minimum
    always_comb
    begin
        tgt = i_invert ? i_free : ~i_free;
        for (int i = 0; i < NUM_BEAMS; i++)
            lrun[i] = !tgt[i] ? 9'h000 : (i == 0 ? 9'h001 : 9'(lrun[i-1] + 9'h001));
        for (int i = NUM_BEAMS - 1; i >= 0; i--)
            rrun[i] = !tgt[i] ? 9'h000 : (i == NUM_BEAMS - 1 ? 9'h001 : 9'(rrun[i+1] + 9'h001));
        for (int i = 0; i < NUM_BEAMS; i++)
        begin
            next_free[i] = i_free[i];
            if (tgt[i] && (i_min > 8'h01) && (10'(lrun[i]) + 10'(rrun[i]) - 10'h001 < 10'(i_min)))
                next_free[i] = ~i_free[i];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_valid <= 1'b0;
            o_free  <= '1;
        end
        else
        begin
            o_valid <= i_valid;
            if (i_valid)
                o_free <= next_free;
        end
    end

    smooth_pass_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_valid && i_min <= 8'h01) |=> (o_free == $past(i_free)))
        else $error("smoothing of one altered the beam vector");
endmodule : bet_beam_smooth

/* bet_scan_model.sv */
`timescale 1ns/1ps
module bet_scan_model
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_meas_start,
    input  wire logic [31:0] i_pattern,
    input  wire logic [15:0] i_level,
    output logic             o_scan_valid,
    output logic [31:0]      o_beam_free,
    output logic [15:0]      o_teach_level
);
    logic [2:0] dly;
    // optics answer a few cycles after each start
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            dly          <= 3'h0;
            o_scan_valid <= 1'b0;
        end
        else
        begin
            dly          <= {dly[1:0], i_meas_start};
            o_scan_valid <= dly[2];
        end
    end
    // outside the strobe the lines flip, so stale data never looks valid
    assign o_beam_free   = o_scan_valid ? i_pattern : ~i_pattern;
    assign o_teach_level = o_scan_valid ? i_level : ~i_level;
endmodule : bet_scan_model

/* beam_evaluation_trigger_logic_bench.sv */
`timescale 1ns/1ps
module beam_evaluation_trigger_logic_bench;
    import bet_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdy = 1'b0, trig = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, pat = '1, free, beams;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [15:0] nv = 16'h1234, lvl = 16'h5678, tlvl, tval, up, lo;
    logic        hrdy, hresp, scan_v, trig_out, ms, tstore, ev;
    int          error_cnt = 0, comparisons = 0, stores = 0;
    // one trigger line shared by the master output and the slave inputs
    wire         trig_line = trig | trig_out;

    initial forever #2.5 clk = ~clk;

    bet_trigger_eval u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hrdy),
        .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata), .i_ready(rdy), .i_scan_valid(scan_v),
        .i_beam_free(free), .i_teach_level(tlvl), .i_nv_teach(nv), .i_trig_in(trig_line),
        .o_trig_out(trig_out), .o_meas_start(ms), .o_teach_store(tstore), .o_teach_value(tval),
        .o_eval_valid(ev), .o_beams_eval(beams), .o_area_bits_upper_word(up), .o_area_bits_lower_word(lo));
    bet_scan_model u_scan (.i_sys_clk(clk), .i_reset_n(rst_n), .i_meas_start(ms), .i_pattern(pat),
        .i_level(lvl), .o_scan_valid(scan_v), .o_beam_free(free), .o_teach_level(tlvl));

    always @(posedge clk) if (tstore === 1'b1) stores++;

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic hang(input string name);
        check(name, 32'h1, 32'h0);
        complete_run();
    endtask : hang
    task automatic bus_wait();
        int n;
        n = 0;
        @(posedge clk);
        while (hrdy !== 1'b1 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        if (hrdy !== 1'b1) hang("hready");
    endtask : bus_wait
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= SIZE_WORD;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= wd;
        bus_wait();
        rd = hrdata;
        check("hresp", 32'h0, {31'h0, hresp});
    endtask : ahb
    task automatic do_teach(input logic [31:0] p, input logic [31:0] c, input logic [31:0] st, input logic [15:0] v,
                            input int n);
        logic [31:0] d;
        int          k, s0;
        pat   <= p;
        rst_n <= 1'b0;
        rdy   <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ahb(OFF_CTRL, 1'b1, c, d);
        s0 = stores;
        rdy   <= 1'b1;
        d = '0;
        for (k = 0; k < 50 && d[0] !== 1'b1; k++) ahb(OFF_STATUS, 1'b0, '0, d);
        check("status", st, d);
        check("teach_value", {16'h0, v}, {16'h0, tval});
        check("teach_stores", n, stores - s0);
    endtask : do_teach
    // a blocked beam must leave the stored value in place
    task automatic teach_fail_test();
        do_teach(32'hFFFF_FFF7, 32'h1, 32'h5, 16'h1234, 0);
    endtask : teach_fail_test
    // teach disabled: the old value stays although the field is clear
    task automatic teach_off_test();
        do_teach(32'hFFFF_FFFF, 32'h0, 32'h1, 16'h1234, 0);
    endtask : teach_off_test
    task automatic teach_ok_test();
        do_teach(32'hFFFF_FFFF, 32'h1, 32'h3, 16'h5678, 1);
    endtask : teach_ok_test
    task automatic trig_scan(input logic [31:0] p, input logic [31:0] eb, input logic [15:0] el, output int k);
        @(posedge clk);
        pat  <= p;
        trig <= 1'b1;
        for (k = 0; k < 1000 && ev !== 1'b1; k++) @(negedge clk);
        if (ev !== 1'b1) hang("eval_valid");
        check("beams_eval", eb, beams);
        @(posedge clk);
        trig <= 1'b0;
        @(negedge clk);
        check("area_lower", {16'h0, el}, {16'h0, lo});
        check("area_upper", 32'h0, {16'h0, up});
        @(posedge clk);
    endtask : trig_scan
    task automatic smooth_area_test();
        logic [31:0] d;
        int          k;
        ahb(OFF_SMOOTH, 1'b1, 32'h3, d);
        ahb(OFF_CTRL, 1'b1, 32'h9, d);
        ahb(OFF_TRIG_DELAY, 1'b1, 32'h2, d);
        ahb(OFF_SMOOTH, 1'b0, '0, d);
        check("smooth", 32'h3, d);
        ahb(12'h0FC, 1'b0, '0, d);
        check("unmapped", 32'h0, d);
        // runs of two and three interrupted beams; only the longer survives
        trig_scan(32'hFFFF_FF8C, 32'hFFFF_FF8F, 16'h0070, k);
        check("trig_delay", 32'h1, {31'h0, k > US_CYC && k < 3 * US_CYC});
        // inverted, three AND areas of 10/10/12 beams; lone free beam 5 is dropped
        ahb(OFF_CTRL, 1'b1, 32'h1D, d);
        ahb(OFF_SPLIT_CNT, 1'b1, 32'h3, d);
        ahb(OFF_SMOOTH, 1'b1, 32'h2, d);
        ahb(OFF_HOLD, 1'b1, 32'h14, d);
        trig_scan(32'hC000_C010, 32'hC000_C000, 16'h0001, k);
        // all free now, but the area bit is held for 20 us
        trig_scan(32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0001, k);
    endtask : smooth_area_test
    task automatic master_test();
        logic [31:0] d;
        int          k, hi;
        // area two watches beams 1..2 by OR; both are blocked from now on
        ahb(OFF_AREA_BASE + 12'h004, 1'b1, 32'h0000_0201, d);
        ahb(OFF_AREA_BASE + 12'h004, 1'b0, '0, d);
        check("area_cfg", 32'h201, d);
        pat <= 32'hFFFF_FFFC;
        ahb(OFF_TRIG_DELAY, 1'b1, 32'h0, d);
        ahb(OFF_TRIG_PERIOD, 1'b1, 32'h1, d);
        ahb(OFF_CTRL, 1'b1, 32'h3, d);
        for (k = 0; k < 1000 && trig_out !== 1'b0; k++) @(negedge clk);
        for (k = 0; k < 1000 && trig_out !== 1'b1; k++) @(negedge clk);
        if (trig_out !== 1'b1) hang("trig_out");
        hi = 1;
        repeat (US_CYC - 1) @(negedge clk) hi += int'(trig_out === 1'b1);
        check("pulse_width", TRIG_PULSE_CYC, hi);
        @(negedge clk);
        check("next_pulse", 32'h1, {31'h0, trig_out});
        check("area_explicit", 32'h2, {16'h0, lo} & 32'h2);
    endtask : master_test

    initial
    begin
        teach_fail_test();
        teach_off_test();
        teach_ok_test();
        smooth_area_test();
        master_test();
        complete_run();
    end
endmodule : beam_evaluation_trigger_logic_bench
